/* design/pes_credit_code.sv */
// Saturating encoder from a signed credit count to a two-bit level code.
// Assumes the count is a plain same-clock value; purely combinational.
`timescale 1ns/1ps
module pes_credit_code #(
  parameter int CRD_W = 8
) (
  input wire logic signed [CRD_W-1:0] crd_count,
  output logic [1:0] crd_code
);
  import pes_pkg::*;

  // Zero or below maps to none, three and above saturate
  always_comb begin
    if (int'(crd_count) < PES_CRD_ONE_N) begin
      crd_code = PES_CRD_NONE; // [R14]
    end else if (int'(crd_count) == PES_CRD_ONE_N) begin
      crd_code = PES_CRD_ONE; // [R14]
    end else if (int'(crd_count) == PES_CRD_TWO_N) begin
      crd_code = PES_CRD_TWO; // [R14]
    end else begin
      crd_code = PES_CRD_MANY; // [R14]
    end
  end

endmodule

/* design/pes_err_class.sv */
// One error class: per-function sticky status bits plus a one-cycle report pulse.
// Assumes events, masks and clears come from same-clock core logic.
`timescale 1ns/1ps
module pes_err_class (
  input wire logic clk,
  input wire logic reset,
  input wire logic root_mode,
  input wire logic [pes_pkg::PES_NUM_PF-1:0] err_event,
  input wire logic [pes_pkg::PES_NUM_PF-1:0] report_en,
  input wire logic [pes_pkg::PES_NUM_PF-1:0] status_clear,
  output logic err_pulse,
  output logic status_any
);
  import pes_pkg::*;

  pes_cls_s st_q;
  pes_cls_s st_d;

  // Status bits are set on any detection, a set beats a same-cycle clear
  always_comb begin
    st_d = st_q;
    st_d.status = (st_q.status & ~status_clear) | err_event;
    if (root_mode) begin
      st_d.pulse = err_event[0] & report_en[0]; // [R09]
    end else begin
      st_d.pulse = |(err_event & report_en); // [R05] [R06] [R07] [R08]
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign err_pulse = st_q.pulse;
  assign status_any = |st_q.status; // [R08]

endmodule

/* design/pes_pkg.sv */
// Shared types and constants for the power, error and flow-control status group.
// Assumes a single user clock domain; all producers sit on that same clock.
//
// Functional notes
// R01: Function power states packed 3 bits each: fn0 [2:0], fn1 [5:3], [11:6] reserved.
// R02: Power codes: 000 D0 uninitialized, 001 D0 active, 010 D1, 100 D3 hot.
// R03: Virtual function states on 24 bits, same coding, vf0 lowest, [23:18] reserved.
// R04: Link power state 00 L0, 01 L0s, 10 L1; 11 (L2) is unsupported.
// R05: Endpoint pulses correctable-error output one cycle per unmasked correctable error.
// R06: Endpoint pulses non-fatal-error output one cycle per unmasked non-fatal error.
// R07: Endpoint pulses fatal-error output one cycle per unmasked fatal error.
// R08: Multi-function endpoint error outputs OR the per-function device status error bits.
// R09: Root port error outputs follow local unmasked errors only, never remote messages.
// R10: User logic must not fully trust error pulses across clocks or all link configs.
// R11: Latency tolerance enable output mirrors function 0 mechanism enable bit.
// R12: User sends latency messages only while enabled, endpoint only; root ignores it.
// R13: Tag-available output reads 1 while at least one request tag is free.
// R14: Header credit code: 00 none or less, 01 one, 10 two, 11 three or more.
// R15: User holds new non-posted requests while credit code is zero or no tag.
package pes_pkg;

  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int PES_NUM_PF = 2;
  localparam int PES_NUM_VF = 6;
  localparam int PES_FLD_W = 3;
  localparam int PES_PF_VEC_W = 12;
  localparam int PES_VF_VEC_W = 24;
  localparam int PES_PF_USED_W = PES_NUM_PF * PES_FLD_W;
  localparam int PES_VF_USED_W = PES_NUM_VF * PES_FLD_W;
  localparam logic [5:0] PES_PF_RSVD = 6'h00;
  localparam logic [5:0] PES_VF_RSVD = 6'h00;

  // ------------------------------------------------------------
  // Encodings
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    PES_D0_UNINIT = 3'b000,
    PES_D0_ACTIVE = 3'b001,
    PES_D1 = 3'b010,
    PES_D3_HOT = 3'b100
  } pes_dstate_e;

  typedef enum logic [1:0] {
    PES_L0 = 2'b00,
    PES_L0S = 2'b01,
    PES_L1 = 2'b10,
    PES_L2 = 2'b11
  } pes_lstate_e;

  localparam logic [1:0] PES_CRD_NONE = 2'b00;
  localparam logic [1:0] PES_CRD_ONE = 2'b01;
  localparam logic [1:0] PES_CRD_TWO = 2'b10;
  localparam logic [1:0] PES_CRD_MANY = 2'b11;
  localparam int PES_CRD_ONE_N = 1;
  localparam int PES_CRD_TWO_N = 2;
  localparam logic [1:0] PES_TAG_NONE = 2'b00;
  localparam logic [1:0] PES_TAG_AVAIL = 2'b01;

  // ------------------------------------------------------------
  // Carriers and state
  // ------------------------------------------------------------
  typedef struct packed {
    logic fatal;
    logic nonfatal;
    logic cor;
  } pes_err_s;

  typedef struct packed {
    logic [PES_NUM_PF-1:0] status;
    logic pulse;
  } pes_cls_s;

  typedef struct packed {
    logic [PES_PF_VEC_W-1:0] pf_pwr;
    logic [PES_VF_VEC_W-1:0] vf_pwr;
    logic [1:0] link_pwr;
    pes_err_s err_pulse;
    pes_err_s err_any;
    logic ltr_en;
    logic [1:0] tag_av;
    logic [1:0] nph;
  } pes_out_s;

endpackage

/* design/pes_status_top.sv */
// Power state, error pulse, latency enable, tag and header credit status outputs.
// Assumes all inputs come from core logic on clk; outputs feed user logic.
`timescale 1ns/1ps
module pes_status_top #(
  parameter int TAG_CNT_W = 6,
  parameter int CRD_W = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic root_port_mode,
  input wire pes_pkg::pes_dstate_e [pes_pkg::PES_NUM_PF-1:0] pf_power_state_in,
  input wire pes_pkg::pes_dstate_e [pes_pkg::PES_NUM_VF-1:0] vf_power_state_in,
  input wire pes_pkg::pes_lstate_e link_power_state_in,
  input wire pes_pkg::pes_err_s [pes_pkg::PES_NUM_PF-1:0] err_event_in,
  input wire pes_pkg::pes_err_s [pes_pkg::PES_NUM_PF-1:0] err_report_en,
  input wire pes_pkg::pes_err_s [pes_pkg::PES_NUM_PF-1:0] err_status_clear,
  input wire logic ltr_mech_enable_pf0,
  input wire logic [TAG_CNT_W-1:0] tags_free,
  input wire logic signed [CRD_W-1:0] nph_credits,
  output logic [pes_pkg::PES_PF_VEC_W-1:0] function_power_state_vector,
  output logic [pes_pkg::PES_VF_VEC_W-1:0] virtual_fn_power_state_vector,
  output logic [1:0] link_power_state,
  output logic err_correctable_pulse,
  output logic err_nonfatal_pulse,
  output logic err_fatal_pulse,
  output pes_pkg::pes_err_s err_status_any,
  output logic ltr_enable,
  output logic [1:0] request_tag_available,
  output logic [1:0] nonposted_header_credit_level
);
  import pes_pkg::*;

  // ------------------------------------------------------------
  // Error classes
  // ------------------------------------------------------------
  logic [PES_NUM_PF-1:0] ev_cor, ev_nf, ev_fat;
  logic [PES_NUM_PF-1:0] en_cor, en_nf, en_fat;
  logic [PES_NUM_PF-1:0] clr_cor, clr_nf, clr_fat;
  pes_err_s cls_pulse;
  pes_err_s cls_any;
  logic [1:0] nph_code;

  // Split the per-function error structs into per-class vectors
  always_comb begin
    for (int i = 0; i < PES_NUM_PF; i++) begin
      ev_cor[i] = err_event_in[i].cor;
      ev_nf[i] = err_event_in[i].nonfatal;
      ev_fat[i] = err_event_in[i].fatal;
      en_cor[i] = err_report_en[i].cor;
      en_nf[i] = err_report_en[i].nonfatal;
      en_fat[i] = err_report_en[i].fatal;
      clr_cor[i] = err_status_clear[i].cor;
      clr_nf[i] = err_status_clear[i].nonfatal;
      clr_fat[i] = err_status_clear[i].fatal;
    end
  end

  pes_err_class u_cor (
    .clk(clk),
    .reset(reset),
    .root_mode(root_port_mode),
    .err_event(ev_cor),
    .report_en(en_cor),
    .status_clear(clr_cor),
    .err_pulse(cls_pulse.cor),
    .status_any(cls_any.cor)
  );

  pes_err_class u_nf (
    .clk(clk),
    .reset(reset),
    .root_mode(root_port_mode),
    .err_event(ev_nf),
    .report_en(en_nf),
    .status_clear(clr_nf),
    .err_pulse(cls_pulse.nonfatal),
    .status_any(cls_any.nonfatal)
  );

  pes_err_class u_fat (
    .clk(clk),
    .reset(reset),
    .root_mode(root_port_mode),
    .err_event(ev_fat),
    .report_en(en_fat),
    .status_clear(clr_fat),
    .err_pulse(cls_pulse.fatal),
    .status_any(cls_any.fatal)
  );

  // ------------------------------------------------------------
  // Credit encoder
  // ------------------------------------------------------------
  pes_credit_code #(
    .CRD_W(CRD_W)
  ) u_nph (
    .crd_count(nph_credits),
    .crd_code(nph_code)
  );

  // ------------------------------------------------------------
  // Output state
  // ------------------------------------------------------------
  pes_out_s st_q;
  pes_out_s st_d;

  // Legal power code check; a reserved code holds the last reported value
  function automatic logic dcode_ok(input logic [2:0] c);
    dcode_ok = (c == PES_D0_UNINIT) || (c == PES_D0_ACTIVE) ||
      (c == PES_D1) || (c == PES_D3_HOT);
  endfunction

  // Next-state for every reported field
  always_comb begin
    st_d = st_q;
    for (int i = 0; i < PES_NUM_PF; i++) begin
      if (dcode_ok(pf_power_state_in[i])) begin
        st_d.pf_pwr[i*PES_FLD_W +: PES_FLD_W] = pf_power_state_in[i]; // [R01] [R02]
      end
    end
    st_d.pf_pwr[PES_PF_VEC_W-1:PES_PF_USED_W] = PES_PF_RSVD; // [R01]
    for (int j = 0; j < PES_NUM_VF; j++) begin
      if (dcode_ok(vf_power_state_in[j])) begin
        st_d.vf_pwr[j*PES_FLD_W +: PES_FLD_W] = vf_power_state_in[j]; // [R03]
      end
    end
    st_d.vf_pwr[PES_VF_VEC_W-1:PES_VF_USED_W] = PES_VF_RSVD; // [R03]
    if (link_power_state_in != PES_L2) begin
      st_d.link_pwr = link_power_state_in; // [R04]
    end
    st_d.err_pulse = cls_pulse; // [R05] [R06] [R07] [R09]
    st_d.err_any = cls_any; // [R08]
    st_d.ltr_en = ltr_mech_enable_pf0; // [R11]
    st_d.tag_av = (tags_free != '0) ? PES_TAG_AVAIL : PES_TAG_NONE; // [R13]
    st_d.nph = nph_code; // [R14]
  end

  // Output register, cleared on reset
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Ports straight from the state register
  assign function_power_state_vector = st_q.pf_pwr;
  assign virtual_fn_power_state_vector = st_q.vf_pwr;
  assign link_power_state = st_q.link_pwr;
  assign err_correctable_pulse = st_q.err_pulse.cor;
  assign err_nonfatal_pulse = st_q.err_pulse.nonfatal;
  assign err_fatal_pulse = st_q.err_pulse.fatal;
  assign err_status_any = st_q.err_any;
  assign ltr_enable = st_q.ltr_en;
  assign request_tag_available = st_q.tag_av;
  assign nonposted_header_credit_level = st_q.nph;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_pf_rsvd;
    @(posedge clk) disable iff (reset)
      function_power_state_vector[PES_PF_VEC_W-1:PES_PF_USED_W] == PES_PF_RSVD;
  endproperty
  a_pf_rsvd: assert property (p_pf_rsvd) else $error("pf reserved bits set"); // [R01]

  property p_pf0_code;
    @(posedge clk) disable iff (reset)
      dcode_ok(pf_power_state_in[0]) |=>
        function_power_state_vector[PES_FLD_W-1:0] == $past(pf_power_state_in[0]);
  endproperty
  a_pf0_code: assert property (p_pf0_code) else $error("pf0 state not reported"); // [R02]

  property p_pf1_code;
    @(posedge clk) disable iff (reset)
      !dcode_ok(pf_power_state_in[1]) |=>
        $stable(function_power_state_vector[2*PES_FLD_W-1:PES_FLD_W]);
  endproperty
  a_pf1_code: assert property (p_pf1_code) else $error("pf1 took reserved code"); // [R02]

  property p_vf_rsvd;
    @(posedge clk) disable iff (reset)
      virtual_fn_power_state_vector[PES_VF_VEC_W-1:PES_VF_USED_W] == PES_VF_RSVD;
  endproperty
  a_vf_rsvd: assert property (p_vf_rsvd) else $error("vf reserved bits set"); // [R03]

  property p_link;
    @(posedge clk) disable iff (reset)
      (link_power_state_in != PES_L2) |=> link_power_state == $past(link_power_state_in);
  endproperty
  a_link: assert property (p_link) else $error("link state mismatch"); // [R04]

  property p_no_l2;
    @(posedge clk) disable iff (reset) link_power_state != PES_L2;
  endproperty
  a_no_l2: assert property (p_no_l2) else $error("unsupported L2 reported"); // [R04]

  sequence s_ep_cor_err;
    !root_port_mode && |(ev_cor & en_cor);
  endsequence

  property p_cor_pulse;
    @(posedge clk) disable iff (reset)
      s_ep_cor_err |-> ##2 err_correctable_pulse;
  endproperty
  a_cor_pulse: assert property (p_cor_pulse) else $error("correctable pulse missing"); // [R05]

  sequence s_quiet_nf;
    !(|(ev_nf & en_nf)) ##1 err_nonfatal_pulse;
  endsequence

  property p_nf_one;
    @(posedge clk) disable iff (reset)
      s_quiet_nf |=> !err_nonfatal_pulse;
  endproperty
  a_nf_one: assert property (p_nf_one) else $error("nonfatal pulse too long"); // [R06]

  property p_fat_cause;
    @(posedge clk) disable iff (reset)
      err_fatal_pulse |-> $past(|(ev_fat & en_fat), 2);
  endproperty
  a_fat_cause: assert property (p_fat_cause) else $error("fatal pulse without cause"); // [R07]

  property p_any_or;
    @(posedge clk) disable iff (reset)
      (|ev_nf) |-> ##2 err_status_any.nonfatal;
  endproperty
  a_any_or: assert property (p_any_or) else $error("status OR missed event"); // [R08]

  property p_root_local;
    @(posedge clk) disable iff (reset)
      (root_port_mode && !(ev_cor[0] && en_cor[0])) |-> ##2 !err_correctable_pulse;
  endproperty
  a_root_local: assert property (p_root_local) else $error("root pulse not local"); // [R09]

  property p_ltr;
    @(posedge clk) disable iff (reset) ##1 ltr_enable == $past(ltr_mech_enable_pf0);
  endproperty
  a_ltr: assert property (p_ltr) else $error("ltr enable not mirrored"); // [R11]

  property p_tag;
    @(posedge clk) disable iff (reset)
      (tags_free != '0) |=> request_tag_available == PES_TAG_AVAIL;
  endproperty
  a_tag: assert property (p_tag) else $error("tag availability wrong"); // [R13]

  property p_nph;
    @(posedge clk) disable iff (reset)
      (int'(nph_credits) < PES_CRD_ONE_N) |=> nonposted_header_credit_level == PES_CRD_NONE;
  endproperty
  a_nph: assert property (p_nph) else $error("credit code not none"); // [R14]

  property p_vf_code;
    @(posedge clk) disable iff (reset)
      dcode_ok(vf_power_state_in[0]) |=>
        virtual_fn_power_state_vector[PES_FLD_W-1:0] == $past(vf_power_state_in[0]);
  endproperty
  a_vf_code: assert property (p_vf_code) else $error("vf0 state not reported"); // [R03]

  sequence s_quiet_cor;
    !(|(ev_cor & en_cor)) ##1 err_correctable_pulse;
  endsequence

  property p_cor_one;
    @(posedge clk) disable iff (reset)
      s_quiet_cor |=> !err_correctable_pulse;
  endproperty
  a_cor_one: assert property (p_cor_one) else $error("correctable pulse too long"); // [R05]

  sequence s_ep_nf_err;
    !root_port_mode && |(ev_nf & en_nf);
  endsequence

  property p_nf_pulse;
    @(posedge clk) disable iff (reset)
      s_ep_nf_err |-> ##2 err_nonfatal_pulse;
  endproperty
  a_nf_pulse: assert property (p_nf_pulse) else $error("nonfatal pulse missing"); // [R06]

  sequence s_ep_fat_err;
    !root_port_mode && |(ev_fat & en_fat);
  endsequence

  property p_fat_pulse;
    @(posedge clk) disable iff (reset)
      s_ep_fat_err |-> ##2 err_fatal_pulse;
  endproperty
  a_fat_pulse: assert property (p_fat_pulse) else $error("fatal pulse missing"); // [R07]

  property p_root_fn1;
    @(posedge clk) disable iff (reset)
      (root_port_mode && ev_fat[1] && !(ev_fat[0] && en_fat[0])) |-> ##2 !err_fatal_pulse;
  endproperty
  a_root_fn1: assert property (p_root_fn1) else $error("root pulse from other fn"); // [R09]

  property p_tag_none;
    @(posedge clk) disable iff (reset)
      (tags_free == '0) |=> request_tag_available == PES_TAG_NONE;
  endproperty
  a_tag_none: assert property (p_tag_none) else $error("tag shown without free tag"); // [R13]

  property p_nph_one;
    @(posedge clk) disable iff (reset)
      (int'(nph_credits) == PES_CRD_ONE_N) |=> nonposted_header_credit_level == PES_CRD_ONE;
  endproperty
  a_nph_one: assert property (p_nph_one) else $error("credit code not one"); // [R14]

  property p_nph_two;
    @(posedge clk) disable iff (reset)
      (int'(nph_credits) == PES_CRD_TWO_N) |=> nonposted_header_credit_level == PES_CRD_TWO;
  endproperty
  a_nph_two: assert property (p_nph_two) else $error("credit code not two"); // [R14]

  property p_nph_many;
    @(posedge clk) disable iff (reset)
      (int'(nph_credits) > PES_CRD_TWO_N) |=> nonposted_header_credit_level == PES_CRD_MANY;
  endproperty
  a_nph_many: assert property (p_nph_many) else $error("credit code not many"); // [R14]

endmodule

/* sim/pes_status_top_bench.sv */
// Self-checking bench for the status group, with the user model on its outputs.
// Assumes pes_pkg is compiled first; inputs change by NBA on clk rising edges.
`timescale 1ns/1ps
module pes_status_top_bench;
  import pes_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic root_port_mode = 1'b0;
  pes_dstate_e [PES_NUM_PF-1:0] pf_power_state_in;
  pes_dstate_e [PES_NUM_VF-1:0] vf_power_state_in;
  pes_lstate_e link_power_state_in = PES_L0;
  pes_err_s [PES_NUM_PF-1:0] err_event_in = '0;
  pes_err_s [PES_NUM_PF-1:0] err_report_en = '0;
  pes_err_s [PES_NUM_PF-1:0] err_status_clear = '0;
  logic ltr_mech_enable_pf0 = 1'b0;
  logic [5:0] tags_free = 6'h00;
  logic signed [7:0] nph_credits = 8'h00;
  logic [11:0] function_power_state_vector;
  logic [23:0] virtual_fn_power_state_vector;
  logic [1:0] link_power_state;
  logic err_correctable_pulse;
  logic err_nonfatal_pulse;
  logic err_fatal_pulse;
  pes_err_s err_status_any;
  logic ltr_enable;
  logic [1:0] request_tag_available;
  logic [1:0] nonposted_header_credit_level;
  logic np_req_ok;
  logic ltr_msg_ok;
  logic [7:0] cor_seen;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;
  logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
  // ----------------------------------------
  // Instances and clock
  // ----------------------------------------
  pes_status_top pes_status_top_i (.clk, .reset, .root_port_mode, .pf_power_state_in,
    .vf_power_state_in, .link_power_state_in, .err_event_in, .err_report_en,
    .err_status_clear, .ltr_mech_enable_pf0, .tags_free, .nph_credits,
    .function_power_state_vector, .virtual_fn_power_state_vector, .link_power_state,
    .err_correctable_pulse, .err_nonfatal_pulse, .err_fatal_pulse, .err_status_any,
    .ltr_enable, .request_tag_available, .nonposted_header_credit_level);
  pes_user_model pes_user_model_i (.clk, .reset, .root_port_mode, .ltr_enable,
    .request_tag_available, .nonposted_header_credit_level, .err_correctable_pulse,
    .np_req_ok, .ltr_msg_ok, .cor_seen_q(cor_seen));
  always #5 clk = ~clk;
  // Hang guard: the tests need well under this many cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      end_sim();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk_vec(input string what, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_flag(input string what, input logic exp, input logic got);
    chk_vec(what, 24'(exp), 24'(got));
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // One event cycle, then the pulse two edges on and gone the cycle after
  task automatic err_shot(input pes_err_s [1:0] e, input logic [2:0] exp_p);
    @(posedge clk);
    err_event_in <= e;
    @(posedge clk);
    err_event_in <= '0;
    @(posedge clk);
    #1;
    chk_vec("err_pulse", 24'(exp_p),
      24'({err_fatal_pulse, err_nonfatal_pulse, err_correctable_pulse}));
    @(posedge clk);
    #1;
    chk_vec("err_pulse_end", 24'h0,
      24'({err_fatal_pulse, err_nonfatal_pulse, err_correctable_pulse}));
  endtask
  // Walks every power code through every field, then reserved codes that must hold
  task automatic test_power();
    logic [2:0] c;
    logic [11:0] pf_exp = '0;
    logic [23:0] vf_exp = '0;
    logic [1:0] lk_exp = '0;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      for (int k = 0; k < PES_NUM_VF; k++) begin
        c = (i == 4 && k == 2) ? 3'h7 : codes[(i + k) % 4];
        vf_power_state_in[k] <= pes_dstate_e'(c);
        if (c != 3'h7) vf_exp[3*k +: 3] = c;
      end
      c = (i == 4) ? 3'h3 : codes[i];
      pf_power_state_in[0] <= pes_dstate_e'(c);
      if (c != 3'h3) pf_exp[2:0] = c;
      c = (i == 4) ? 3'h6 : codes[3 - (i % 4)];
      pf_power_state_in[1] <= pes_dstate_e'(c);
      if (c != 3'h6) pf_exp[5:3] = c;
      link_power_state_in <= pes_lstate_e'(i[1:0]);
      if (i[1:0] != 2'b11) lk_exp = i[1:0];
      repeat (2) @(posedge clk);
      #1;
      chk_vec("pf_power", 24'(pf_exp), 24'(function_power_state_vector));
      chk_vec("vf_power", vf_exp, virtual_fn_power_state_vector);
      chk_vec("link_power", 24'(lk_exp), 24'(link_power_state));
    end
    $display("test power done");
  endtask
  // Credit, tag and latency enable table with the user gating beside it
  task automatic test_flow();
    int crd [6] = '{-2, 0, 1, 2, 3, 127};
    logic [1:0] lvl [6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      nph_credits <= 8'(crd[i]);
      tags_free <= 6'((i % 3) * 31);
      ltr_mech_enable_pf0 <= i[0];
      root_port_mode <= i[2];
      repeat (2) @(posedge clk);
      #1;
      chk_vec("nph_level", 24'(lvl[i]), 24'(nonposted_header_credit_level));
      chk_vec("tag_av", 24'((i % 3) != 0), 24'(request_tag_available));
      chk_flag("ltr_enable", i[0], ltr_enable);
      chk_flag("np_req_ok", (i % 3) != 0 && lvl[i] != 2'h0, np_req_ok);
      chk_flag("ltr_msg_ok", i[0] && !i[2], ltr_msg_ok);
    end
    $display("test flow done");
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    for (int k = 0; k < PES_NUM_PF; k++) pf_power_state_in[k] = PES_D0_UNINIT;
    for (int k = 0; k < PES_NUM_VF; k++) vf_power_state_in[k] = PES_D0_UNINIT;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    test_power();
    @(posedge clk);
    err_report_en <= 6'b111111;
    err_shot(6'b001000, 3'b001);
    chk_vec("err_status", 24'h1, 24'(err_status_any));
    err_shot(6'b100010, 3'b110);
    chk_vec("err_status", 24'h7, 24'(err_status_any));
    @(posedge clk);
    err_report_en <= 6'b000111;
    err_shot(6'b001000, 3'b000);
    @(posedge clk);
    err_status_clear <= 6'b111111;
    @(posedge clk);
    err_status_clear <= '0;
    repeat (3) @(posedge clk);
    #1;
    chk_vec("err_status_clr", 24'h0, 24'(err_status_any));
    // Event and clear in one cycle: the set must win
    @(posedge clk);
    err_event_in <= 6'b000001;
    err_status_clear <= 6'b000001;
    @(posedge clk);
    err_event_in <= '0;
    err_status_clear <= '0;
    repeat (2) @(posedge clk);
    #1;
    chk_vec("err_status_set_wins", 24'h1, 24'(err_status_any));
    $display("test endpoint errors done");
    @(posedge clk);
    root_port_mode <= 1'b1;
    err_report_en <= 6'b111111;
    err_shot(6'b101000, 3'b000);
    err_shot(6'b000100, 3'b100);
    $display("test root errors done");
    @(posedge clk);
    root_port_mode <= 1'b0;
    test_flow();
    chk_vec("cor_seen", 24'h2, 24'(cor_seen));
    end_sim();
  end
endmodule

/* sim/pes_user_model.sv */
// User logic model that consumes the status group outputs.
// Assumes every input except clk, reset and root_port_mode comes from pes_status_top on the same clk.
`timescale 1ns/1ps
module pes_user_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic root_port_mode,
  input wire logic ltr_enable,
  input wire logic [1:0] request_tag_available,
  input wire logic [1:0] nonposted_header_credit_level,
  input wire logic err_correctable_pulse,
  output logic np_req_ok,
  output logic ltr_msg_ok,
  output logic [7:0] cor_seen_q
);
  import pes_pkg::*;
  // ----------------------------------------
  // Request gating
  // ----------------------------------------
  // New non-posted requests need a free tag and a nonzero credit code
  assign np_req_ok = (request_tag_available == PES_TAG_AVAIL) &&
                     (nonposted_header_credit_level != PES_CRD_NONE);
  // Latency messages only as an endpoint, and only while enabled
  assign ltr_msg_ok = ltr_enable && !root_port_mode;
  // Pulses are only hints here; the error record lives elsewhere
  always_ff @(posedge clk) begin
    if (reset) begin
      cor_seen_q <= 8'h00;
    end else if (err_correctable_pulse) begin
      cor_seen_q <= cor_seen_q + 8'h01;
    end
  end
endmodule
